/* File: hw/exception_vector_interrupt_regs.v */
// exception vectors, status reset bits, context and revision registers,
// interrupt cause summary and vector read registers with acknowledge cycle.
// assumes: processor ports and peripheral acknowledge logic share clock;
// cause pins are asynchronous and are synchronised here.
//
// Notes on behaviour
// - context upper field bits 31..21 holds software page table base
// - context bits 20..2 read-only, loaded with failing page on fault
// - revision reads implementation 15..8, revision 7..0, upper half zero
// - cause summary readable by main and diagnostic processor at own addresses
// - cause summary bits 31..4 always read as ones
// - cause bit 3 reads set while halt request is posted
// - bit 2 power fail, cleared at reset, blocks until zero written
// - bit 1 memory error, cleared at reset, waits until zero written
// - bit 0 write error marks address valid, cleared, rearm by zero
// - vector read runs acknowledge cycle, vector returned in bits 15..0
// - no acknowledge answer ends vector read with bus error
// - vector reads at four addresses serve levels 14..17, 17 highest
// - only main processor reaches vector reads, diagnostic accesses do not
// - side-effect lower requests drop when the higher request drops
// - boot bit clear: miss and general vectors normal, reset vector stays in rom
// - boot bit set: miss and general vectors move into rom space
// - general vector serves address, bus, break, cop, int, ovf, ri, tlb
// - reset exception taken on reset release, vector in first rom word
// - reset clears shutdown, swap, user, int enable; sets boot; clears random
// - status bit 22 selects alternate boot vectors when one
`timescale 1ns/1ps
`include "exception_vector_interrupt_regs_consts.vh"

module exception_vector_interrupt_regs #(
    parameter [7:0]  IMPLEMENTATION_CODE = 8'h5a, // arbitrary value
    parameter [7:0]  REVISION_CODE       = 8'h01, // arbitrary value
    parameter        IACK_TIMEOUT_CYCLES =
        (`IACK_TIMEOUT_NS * `CLOCK_MHZ + 999) / 1000
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // main processor register port
    input  wire        main_req,
    input  wire        main_we,
    input  wire [31:0] main_addr,
    input  wire [31:0] main_wdata,
    output reg         main_ack_q,
    output reg         main_bus_error_q,
    output reg  [31:0] main_rdata_q,
    // diagnostic processor register port
    input  wire        diag_req,
    input  wire        diag_we,
    input  wire [31:0] diag_addr,
    input  wire [31:0] diag_wdata,
    output reg         diag_ack_q,
    output reg         diag_bus_error_q,
    output reg  [31:0] diag_rdata_q,
    // asynchronous cause pins
    input  wire        halt_request_pin,
    input  wire        power_fail_pin,
    input  wire        memory_error_pin,
    input  wire        write_error_pin,
    // peripheral interrupt requests and acknowledge cycle, levels 14..17
    input  wire [3:0]  irq_level_in,
    output reg  [3:0]  irq_pending_q,
    output reg         iack_req_q,
    output reg  [1:0]  iack_level_q,
    input  wire        iack_done,
    input  wire [15:0] iack_vector,
    // context register
    input  wire        context_we,
    input  wire [31:0] context_wdata,
    input  wire        address_fault,
    input  wire [18:0] failing_page_number,
    output reg  [31:0] context_pointer_q,
    // revision register
    output reg  [31:0] chip_revision_id_q,
    // status bits
    input  wire        status_we,
    input  wire [31:0] status_wdata,
    output reg         boot_vector_select_q,
    output reg         translation_shutdown_q,
    output reg         cache_swap_q,
    output reg         current_user_mode_q,
    output reg         current_int_enable_q,
    output reg  [5:0]  random_q,
    // exception vectoring
    input  wire        exception_valid,
    input  wire [1:0]  exception_kind,
    output reg         vector_valid_q,
    output reg  [31:0] vector_address_q
);

    localparam ST_IDLE = 1'b0;
    localparam ST_IACK = 1'b1;
    localparam TIMER_W = 16;

    // one synchroniser per cause pin
    reg  [3:0] sync1_q;
    reg  [3:0] sync2_q;
    reg  [3:0] sync3_q;
    reg  [3:0] level_q;
    wire [3:0] pins = {halt_request_pin, power_fail_pin, memory_error_pin,
                       write_error_pin};
    // level moves only once two later stages agree; a one-cycle glitch is dropped
    wire [3:0] agree = ~(sync2_q ^ sync3_q);
    wire [3:0] level_d = (agree & sync2_q) | (~agree & level_q);
    wire [3:0] rise = level_d & ~level_q;

    reg  [2:0] flags_q;
    reg        halt_q;
    reg  [3:0] shadow_q;
    reg  [3:0] irq_prev_q;
    reg        state_q;
    reg  [TIMER_W-1:0] timer_q;
    reg        reset_seen_q;

    // unused bits are constant ones, so writes there cannot reach them
    function [31:0] cause_word;
        input       halt;
        input [2:0] flags;
        begin
            cause_word = {`CAUSE_UNUSED_ONES, halt, flags};
        end
    endfunction

    // full decode: aliases of the vector addresses give a bus error
    function [2:0] vector_hit;
        input [31:0] addr;
        begin
            vector_hit = 3'h0;
            case (addr)
                `ADDR_VECTOR_LEVEL14: vector_hit = 3'h4;
                `ADDR_VECTOR_LEVEL15: vector_hit = 3'h5;
                `ADDR_VECTOR_LEVEL16: vector_hit = 3'h6;
                `ADDR_VECTOR_LEVEL17: vector_hit = 3'h7;
                default:              vector_hit = 3'h0;
            endcase
        end
    endfunction

    function [31:0] vector_for;
        input [1:0] kind;
        input       boot;
        begin
            case (kind)
                `EXC_KIND_RESET: vector_for = `VEC_RESET;
                `EXC_KIND_MISS:
                    vector_for = boot ? `VEC_MISS_BOOT : `VEC_MISS_NORMAL;
                default:
                    vector_for = boot ? `VEC_GENERAL_BOOT : `VEC_GENERAL_NORMAL;
            endcase
        end
    endfunction

    wire [2:0] main_vec     = vector_hit(main_addr);
    wire       main_cause   = main_addr == `ADDR_CAUSE_MAIN;
    wire       diag_cause   = diag_addr == `ADDR_CAUSE_DIAG;
    wire       main_clr     = main_req & main_we & main_cause & (state_q == ST_IDLE);
    wire       diag_clr     = diag_req & diag_we & diag_cause;
    wire [2:0] clear_mask   = (main_clr ? ~main_wdata[2:0] : 3'h0)
                            | (diag_clr ? ~diag_wdata[2:0] : 3'h0);
    wire [2:0] flag_events  = {rise[`CAUSE_POWER_FAIL_BIT], rise[`CAUSE_MEM_ERROR_BIT],
                               rise[`CAUSE_WRITE_ERROR_BIT]};

    // lower levels raised under a higher request are tracked separately
    reg  [3:0] higher_active;
    integer    i;
    always @* begin
        higher_active = 4'h0;
        for (i = 0; i < 3; i = i + 1) begin
            higher_active[i] = |(irq_level_in >> (i + 1));
        end
    end
    wire [3:0] irq_rise = irq_level_in & ~irq_prev_q;

    // synchronisers and filtered levels
    always @(posedge clock) begin
        if (rst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            level_q <= 4'h0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= level_d;
        end
    end

    // cause summary; set wins over a clear in the same cycle
    always @(posedge clock) begin
        if (rst) begin
            flags_q <= 3'h0;
            halt_q  <= 1'b0;
        end else begin
            // halt is a plain level, nothing to clear
            halt_q  <= level_d[`CAUSE_HALT_BIT];
            flags_q <= (flags_q & ~clear_mask) | flag_events;
        end
    end

    // request filtering of side-effect lower levels
    always @(posedge clock) begin
        if (rst) begin
            shadow_q      <= 4'h0;
            irq_prev_q    <= 4'h0;
            irq_pending_q <= 4'h0;
        end else begin
            irq_prev_q    <= irq_level_in;
            // a shadowed level is masked once no higher request remains, until its own raw request falls;
            // a real request raised at that level under a higher one is hidden too
            shadow_q      <= (shadow_q | (irq_rise & higher_active)) & irq_level_in;
            irq_pending_q <= irq_level_in & ~(shadow_q & ~higher_active);
        end
    end

    // main processor port and acknowledge cycle
    always @(posedge clock) begin
        if (rst) begin
            state_q          <= ST_IDLE;
            timer_q          <= {TIMER_W{1'b0}};
            iack_req_q       <= 1'b0;
            iack_level_q     <= 2'h0;
            main_ack_q       <= 1'b0;
            main_bus_error_q <= 1'b0;
            main_rdata_q     <= 32'h00000000;
        end else begin
            main_ack_q       <= 1'b0;
            main_bus_error_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (main_req) begin
                        if (main_cause) begin
                            main_ack_q   <= 1'b1;
                            if (!main_we) begin
                                main_rdata_q <= cause_word(halt_q, flags_q);
                            end
                        end else if (main_vec[2] && main_we) begin
                            main_ack_q   <= 1'b1;
                        end else if (main_vec[2]) begin
                            state_q      <= ST_IACK;
                            iack_req_q   <= 1'b1;
                            iack_level_q <= main_vec[1:0];
                            timer_q      <= {TIMER_W{1'b0}};
                        end else begin
                            main_bus_error_q <= 1'b1;
                        end
                    end
                end
                // a request made here gets no answer at all; masters must wait
                ST_IACK: begin
                    // no responder: give up after the timeout rather than hang the master
                    if (iack_done) begin
                        state_q      <= ST_IDLE;
                        iack_req_q   <= 1'b0;
                        main_ack_q   <= 1'b1;
                        main_rdata_q <= {16'hffff, iack_vector};
                    end else if (timer_q == IACK_TIMEOUT_CYCLES[TIMER_W-1:0] - 1'b1) begin
                        state_q          <= ST_IDLE;
                        iack_req_q       <= 1'b0;
                        main_bus_error_q <= 1'b1;
                    end else begin
                        timer_q <= timer_q + 1'b1;
                    end
                end
                default: begin
                    state_q    <= ST_IDLE;
                    iack_req_q <= 1'b0;
                end
            endcase
        end
    end

    // diagnostic processor port: cause summary only
    always @(posedge clock) begin
        if (rst) begin
            diag_ack_q       <= 1'b0;
            diag_bus_error_q <= 1'b0;
            diag_rdata_q     <= 32'h00000000;
        end else begin
            diag_ack_q       <= diag_req & diag_cause;
            diag_bus_error_q <= diag_req & ~diag_cause;
            if (diag_req && diag_cause && !diag_we) begin
                diag_rdata_q <= cause_word(halt_q, flags_q);
            end
        end
    end

    // context and revision registers
    always @(posedge clock) begin
        if (rst) begin
            context_pointer_q  <= 32'h00000000;
            chip_revision_id_q <= 32'h00000000;
        end else begin
            chip_revision_id_q <= {16'h0000, IMPLEMENTATION_CODE, REVISION_CODE};
            if (context_we) begin
                context_pointer_q[`CTX_BASE_HI:`CTX_BASE_LO] <=
                    context_wdata[`CTX_BASE_HI:`CTX_BASE_LO];
            end
            // base write and fault touch disjoint fields, so both may land at once
            if (address_fault) begin
                context_pointer_q[`CTX_PAGE_HI:`CTX_PAGE_LO] <= failing_page_number;
            end
        end
    end

    // status bits and exception vectoring
    always @(posedge clock) begin
        if (rst) begin
            boot_vector_select_q   <= `SR_BOOT_VECTOR_RESET;
            translation_shutdown_q <= `SR_CLEARED_RESET;
            cache_swap_q           <= `SR_CLEARED_RESET;
            current_user_mode_q    <= `SR_CLEARED_RESET;
            current_int_enable_q   <= `SR_CLEARED_RESET;
            random_q               <= `RANDOM_RESET;
            reset_seen_q           <= 1'b0;
            vector_valid_q         <= 1'b0;
            vector_address_q       <= 32'h00000000;
        end else begin
            if (status_we) begin
                boot_vector_select_q   <= status_wdata[`SR_BOOT_VECTOR_BIT];
                translation_shutdown_q <= status_wdata[`SR_TRANS_SHUT_BIT];
                cache_swap_q           <= status_wdata[`SR_CACHE_SWAP_BIT];
                current_user_mode_q    <= status_wdata[`SR_USER_MODE_BIT];
                current_int_enable_q   <= status_wdata[`SR_INT_ENABLE_BIT];
            end
            // first cycle out of reset reports the reset exception itself
            reset_seen_q   <= 1'b1;
            vector_valid_q <= ~reset_seen_q | exception_valid;
            if (!reset_seen_q) begin
                vector_address_q <= `VEC_RESET;
            end else if (exception_valid) begin
                vector_address_q <= vector_for(exception_kind, boot_vector_select_q);
            end
        end
    end

endmodule

/* File: hw/exception_vector_interrupt_regs_consts.vh */
// constants for the exception, vector read and interrupt summary block
// assumes 32-bit byte addresses on both processor ports and a 200 MHz clock
`ifndef EXCEPTION_VECTOR_INTERRUPT_REGS_CONSTS_VH
`define EXCEPTION_VECTOR_INTERRUPT_REGS_CONSTS_VH

// register addresses
`define ADDR_CAUSE_MAIN       32'h10084000
`define ADDR_CAUSE_DIAG       32'h20084000
`define ADDR_VECTOR_LEVEL14   32'h16000050
`define ADDR_VECTOR_LEVEL15   32'h16000054
`define ADDR_VECTOR_LEVEL16   32'h16000058
`define ADDR_VECTOR_LEVEL17   32'h1600005c

// interrupt cause summary fields
`define CAUSE_HALT_BIT        3
`define CAUSE_POWER_FAIL_BIT  2
`define CAUSE_MEM_ERROR_BIT   1
`define CAUSE_WRITE_ERROR_BIT 0
`define CAUSE_UNUSED_ONES     28'hfffffff

// context register fields
`define CTX_BASE_HI           31
`define CTX_BASE_LO           21
`define CTX_PAGE_HI           20
`define CTX_PAGE_LO           2

// revision register fields
`define REV_IMP_LO            8
`define REV_IMP_HI            15

// status register bits
`define SR_BOOT_VECTOR_BIT    22
`define SR_TRANS_SHUT_BIT     21
`define SR_CACHE_SWAP_BIT     17
`define SR_USER_MODE_BIT      1
`define SR_INT_ENABLE_BIT     0

// status reset values
`define SR_BOOT_VECTOR_RESET  1'b1
`define SR_CLEARED_RESET      1'b0
`define RANDOM_RESET          6'h00

// exception vectors
`define VEC_RESET             32'hbfc00000
`define VEC_MISS_NORMAL       32'h80000000
`define VEC_GENERAL_NORMAL    32'h80000080
`define VEC_MISS_BOOT         32'hbfc00100
`define VEC_GENERAL_BOOT      32'hbfc00180
`define VEC_RESET_PHYSICAL    32'h1fc00000

// exception kinds
`define EXC_KIND_RESET        2'h0
`define EXC_KIND_MISS         2'h1
`define EXC_KIND_GENERAL      2'h2

// timing
`define CLOCK_MHZ             200
`define IACK_TIMEOUT_NS       1000

`endif

/* File: sim/exception_vector_interrupt_regs_sva.sv */
// checker for the exception, vector read and cause summary block
// sees only the top ports; bound to every instance at the foot of this file
`timescale 1ns/1ps
`include "exception_vector_interrupt_regs_consts.vh"
module exception_vector_interrupt_regs_chk #(
    parameter IACK_TIMEOUT_CYCLES = 200
) (
    // clock, reset and processor ports (packed to save room)
    input wire        clock, rst, main_req, main_we, main_ack_q, main_bus_error_q,
    input wire        diag_req, diag_we, diag_ack_q, diag_bus_error_q,
    input wire [31:0] main_addr, main_rdata_q, diag_addr, diag_rdata_q,
    // acknowledge cycle
    input wire        iack_req_q, iack_done,
    input wire [1:0]  iack_level_q,
    input wire [15:0] iack_vector,
    // context, revision, status and vectoring
    input wire        context_we, address_fault, exception_valid, vector_valid_q,
    input wire [31:0] context_wdata, context_pointer_q, chip_revision_id_q, vector_address_q,
    input wire [18:0] failing_page_number,
    input wire        boot_vector_select_q, translation_shutdown_q, cache_swap_q,
    input wire        current_user_mode_q, current_int_enable_q,
    input wire [5:0]  random_q,
    input wire [1:0]  exception_kind
);
    logic [15:0] wait_q;
    wire         main_rd = main_req && !main_we && !iack_req_q;
    wire [31:0]  exp_vec = exception_kind == `EXC_KIND_RESET ? `VEC_RESET :
        exception_kind == `EXC_KIND_MISS ?
        (boot_vector_select_q ? `VEC_MISS_BOOT : `VEC_MISS_NORMAL) :
        (boot_vector_select_q ? `VEC_GENERAL_BOOT : `VEC_GENERAL_NORMAL);

    // length of the current acknowledge wait
    always @(posedge clock)
        if (rst || !iack_req_q) wait_q <= 16'h0000;
        else wait_q <= wait_q + 16'h0001;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    cause_main_ones_a: assert property (
        main_rd && main_addr == `ADDR_CAUSE_MAIN |=> main_ack_q &&
        main_rdata_q[31:4] == `CAUSE_UNUSED_ONES) else $error("main cause read wrong");
    cause_diag_ones_a: assert property (
        diag_req && !diag_we && diag_addr == `ADDR_CAUSE_DIAG |=> diag_ack_q &&
        diag_rdata_q[31:4] == `CAUSE_UNUSED_ONES) else $error("diag cause read wrong");
    diag_vector_refused_a: assert property (
        diag_req && diag_addr[31:4] == 28'h1600005 |=> diag_bus_error_q && !diag_ack_q)
        else $error("diag reached a vector register");
    iack_start_a: assert property (
        main_rd && main_addr[31:4] == 28'h1600005 && main_addr[1:0] == 2'h0 |=>
        iack_req_q && iack_level_q == $past(main_addr[3:2])) else $error("no iack cycle");
    iack_answer_a: assert property (
        iack_req_q && iack_done |=> !iack_req_q && main_ack_q &&
        main_rdata_q == {16'hffff, $past(iack_vector)}) else $error("vector data wrong");
    iack_timeout_a: assert property (
        $fell(iack_req_q) && !$past(iack_done) |-> main_bus_error_q && !main_ack_q &&
        wait_q == IACK_TIMEOUT_CYCLES)
        else $error("unanswered iack without bus error");
    iack_bound_a: assert property (wait_q <= IACK_TIMEOUT_CYCLES)
        else $error("iack wait too long");
    exc_vector_a: assert property (
        exception_valid |=> vector_valid_q && vector_address_q == $past(exp_vec))
        else $error("exception vector wrong");
    reset_vector_a: assert property (
        $fell(rst) |=> vector_valid_q && vector_address_q == `VEC_RESET)
        else $error("no reset exception");
    reset_status_a: assert property (
        $fell(rst) |-> boot_vector_select_q && !translation_shutdown_q && !cache_swap_q &&
        !current_user_mode_q && !current_int_enable_q && random_q == 6'h00)
        else $error("status reset values wrong");
    context_page_a: assert property (
        address_fault |=> context_pointer_q[20:2] == $past(failing_page_number))
        else $error("failing page not loaded");
    context_base_a: assert property (
        context_we |=> context_pointer_q[31:21] == $past(context_wdata[31:21]))
        else $error("page table base not written");
    revision_upper_a: assert property (chip_revision_id_q[31:16] == 16'h0000)
        else $error("revision upper half not zero");

    cover property (iack_req_q && iack_done);
    cover property ($fell(iack_req_q) && main_bus_error_q);
    cover property (exception_valid && !boot_vector_select_q);
endmodule

bind exception_vector_interrupt_regs exception_vector_interrupt_regs_chk #(
    .IACK_TIMEOUT_CYCLES(IACK_TIMEOUT_CYCLES)) exception_vector_interrupt_regs_chk_i (.*);

/* File: sim/peripheral_iack_model.sv */
// interrupting peripheral answering acknowledge cycles
// same clock as the block; delay sets a slow answer, mute models no responder
`timescale 1ns/1ps
module peripheral_iack_model (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // acknowledge cycle from the block
    input  wire        iack_req_q,
    input  wire [1:0]  iack_level_q,
    // scenario controls
    input  wire [1:0]  delay,
    input  wire        mute,
    // answer
    output logic       iack_done,
    output logic [15:0] iack_vector
);
    logic [1:0] cnt_q;
    wire        fire = iack_req_q && !mute && cnt_q == delay;

    always @(posedge clock) begin
        cnt_q <= (rst || !iack_req_q) ? 2'h0 : cnt_q + 2'h1;
        iack_done <= fire;
        // vector bus only meaningful with the answer; otherwise it toggles
        iack_vector <= fire ? {14'h3000, iack_level_q} : rst ? 16'h5555 : ~iack_vector;
    end
endmodule

/* File: sim/exception_vector_interrupt_regs_tb.sv */
// self-checking bench for the exception, vector read and cause summary block
// drives both processor ports and the pins; peripheral model answers iack cycles
`timescale 1ns/1ps
`include "exception_vector_interrupt_regs_consts.vh"
module exception_vector_interrupt_regs_tb;
    logic clock, rst, main_req, main_we, diag_req, diag_we, iack_done, context_we;
    logic halt_request_pin, power_fail_pin, memory_error_pin, write_error_pin;
    logic address_fault, status_we, exception_valid, mute, er;
    logic main_ack_q, main_bus_error_q, diag_ack_q, diag_bus_error_q, iack_req_q;
    logic boot_vector_select_q, translation_shutdown_q, cache_swap_q, vector_valid_q;
    logic current_user_mode_q, current_int_enable_q;
    logic [31:0] main_addr, main_wdata, main_rdata_q, diag_addr, diag_wdata, diag_rdata_q;
    logic [31:0] context_wdata, context_pointer_q, chip_revision_id_q, status_wdata;
    logic [31:0] vector_address_q, rd;
    logic [3:0]  irq_level_in, irq_pending_q;
    logic [1:0]  iack_level_q, exception_kind, delay;
    logic [15:0] iack_vector;
    logic [18:0] failing_page_number;
    logic [5:0]  random_q;
    integer      n_fail = 0, n_compared = 0, cyc = 0, j;
    wire  [31:0] status_bits = {27'h0, boot_vector_select_q, translation_shutdown_q,
                                cache_swap_q, current_user_mode_q, current_int_enable_q};

    // codes are arbitrary values
    exception_vector_interrupt_regs #(.IMPLEMENTATION_CODE(8'h3c), .REVISION_CODE(8'h07),
        .IACK_TIMEOUT_CYCLES(8)) exception_vector_interrupt_regs_i (.*);
    peripheral_iack_model peripheral_iack_model_i (.*);

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end

    task tk(input integer n);
        repeat (n) @(posedge clock);
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared = n_compared + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one access on the main (dg=0) or diagnostic (dg=1) port; result in rd and er
    task acc(input logic dg, input logic we, input logic [31:0] a, input logic [31:0] d);
        integer i;
        main_req <= !dg;
        diag_req <= dg;
        main_we <= we;
        diag_we <= we;
        main_addr <= a;
        diag_addr <= a;
        main_wdata <= d;
        diag_wdata <= d;
        tk(1);
        main_req <= 1'b0;
        diag_req <= 1'b0;
        er = 1'bx;
        rd = 32'hx;
        for (i = 0; i < 40; i++) begin
            tk(1);
            if ((dg ? diag_ack_q | diag_bus_error_q : main_ack_q | main_bus_error_q) === 1'b1) begin
                rd = dg ? diag_rdata_q : main_rdata_q;
                er = dg ? diag_bus_error_q : main_bus_error_q;
                i = 40;
            end
        end
    endtask

    task stat(input logic [31:0] d);
        status_we <= 1'b1;
        status_wdata <= d;
        tk(1);
        status_we <= 1'b0;
        tk(1);
    endtask

    task ctx(input logic we, input logic f, input logic [31:0] d, input logic [18:0] p);
        context_we <= we;
        address_fault <= f;
        context_wdata <= d;
        failing_page_number <= p;
        tk(1);
        context_we <= 1'b0;
        address_fault <= 1'b0;
        tk(1);
    endtask

    task rst_cycle;
        rst <= 1'b1;
        tk(5);
        rst <= 1'b0;
        tk(2);
        chk("status", 32'h10, status_bits);
        chk("random", 32'h0, {26'h0, random_q});
        chk("reset vector", 32'hbfc00000, vector_address_q);
    endtask

    function automatic logic [31:0] exp_vec(input logic [1:0] k, input logic b);
        if (k == 2'h0) return 32'hbfc00000;
        if (k == 2'h1) return b ? 32'hbfc00100 : 32'h80000000;
        return b ? 32'hbfc00180 : 32'h80000080;
    endfunction

    initial begin
        {main_req, main_we, diag_req, diag_we, context_we, address_fault, status_we} = 7'h00;
        {halt_request_pin, power_fail_pin, memory_error_pin, write_error_pin} = 4'h0;
        {exception_valid, exception_kind, mute, delay, irq_level_in} = 10'h000;
        {main_addr, main_wdata, diag_addr, diag_wdata, context_wdata, status_wdata} = 192'h0;
        failing_page_number = 19'h0;
        rst = 1'b1;
        rst_cycle;
        chk("revision", 32'h00003c07, chip_revision_id_q);
        for (j = 0; j < 8; j++) begin
            if (j == 4) stat(32'h0);
            exception_valid <= 1'b1;
            exception_kind <= j[1:0];
            tk(1);
            exception_valid <= 1'b0;
            tk(1);
            chk("vector", exp_vec(j[1:0], j < 4), vector_address_q);
        end
        stat(32'h00620003);
        chk("status set", 32'h1f, status_bits);
        rst_cycle;
        ctx(1'b1, 1'b0, 32'hffffffff, 19'h0);
        chk("context", 32'hffe00000, context_pointer_q);
        ctx(1'b0, 1'b1, 32'h0, 19'h5a5a5);
        chk("context", 32'hfff69694, context_pointer_q);
        ctx(1'b1, 1'b0, 32'h0, 19'h0);
        chk("context", 32'h00169694, context_pointer_q);
        {power_fail_pin, memory_error_pin, write_error_pin} <= 3'h7;
        tk(6);
        {power_fail_pin, memory_error_pin, write_error_pin} <= 3'h0;
        tk(8);
        acc(1'b0, 1'b0, `ADDR_CAUSE_MAIN, 32'h0);
        chk("cause", 32'hfffffff7, rd);
        acc(1'b0, 1'b1, `ADDR_CAUSE_MAIN, 32'hfffffffb);
        acc(1'b0, 1'b0, `ADDR_CAUSE_MAIN, 32'h0);
        chk("cause", 32'hfffffff3, rd);
        halt_request_pin <= 1'b1;
        tk(8);
        acc(1'b1, 1'b0, `ADDR_CAUSE_DIAG, 32'h0);
        chk("cause diag", 32'hfffffffb, rd);
        halt_request_pin <= 1'b0;
        tk(8);
        acc(1'b1, 1'b1, `ADDR_CAUSE_DIAG, 32'h0);
        acc(1'b0, 1'b0, `ADDR_CAUSE_MAIN, 32'h0);
        chk("cause", 32'hfffffff0, rd);
        acc(1'b0, 1'b0, 32'h10084004, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        acc(1'b1, 1'b0, `ADDR_VECTOR_LEVEL17, 32'h0);
        chk("diag vector error", 32'h1, {31'h0, er});
        for (j = 0; j < 4; j++) begin
            delay <= j[1:0];
            acc(1'b0, 1'b0, `ADDR_VECTOR_LEVEL14 + 32'h4 * j, 32'h0);
            chk("vector read", 32'hffffc000 | j, rd);
        end
        acc(1'b0, 1'b1, `ADDR_VECTOR_LEVEL14, 32'h0);
        chk("vector write", 32'h0, {30'h0, iack_req_q, er});
        mute <= 1'b1;
        acc(1'b0, 1'b0, `ADDR_VECTOR_LEVEL15, 32'h0);
        chk("no answer error", 32'h1, {31'h0, er});
        mute <= 1'b0;
        irq_level_in <= 4'h1;
        tk(3);
        chk("pending", 32'h1, {28'h0, irq_pending_q});
        irq_level_in <= 4'h8;
        tk(2);
        irq_level_in <= 4'h9;
        tk(3);
        chk("pending", 32'h9, {28'h0, irq_pending_q});
        acc(1'b0, 1'b0, `ADDR_VECTOR_LEVEL17, 32'h0);
        chk("vector read", 32'hffffc003, rd);
        irq_level_in <= 4'h1;
        tk(3);
        chk("pending", 32'h0, {28'h0, irq_pending_q});
        final_report;
    end
endmodule
